//--- core/usb_irq_pkg.sv
/*
 * Shared constants and carriers for the USB, keyboard-line and GPIO interrupt sources.
 * Assumes an 8-bit register bus and a 100 MHz core clock.
 */
package usb_irq_pkg;

  // Register byte addresses on the 8-bit bus.
  localparam logic [7:0] ADR_PA_EN = 8'h04;
  localparam logic [7:0] ADR_PB_EN = 8'h05;
  localparam logic [7:0] ADR_PA_POL = 8'h06;
  localparam logic [7:0] ADR_PB_POL = 8'h07;
  localparam logic [7:0] ADR_USB_CTL = 8'h1f;
  localparam logic [7:0] ADR_GLB_EN = 8'h20;
  localparam logic [7:0] ADR_EP_EN = 8'h21;
  localparam logic [7:0] ADR_STATUS = 8'h22;
  localparam logic [7:0] ADR_CLEAR = 8'h23;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_EP = 2'h0;
  localparam logic RST_SEL = 1'b0;

  // Bit positions in the status, clear, global enable, endpoint enable and control registers.
  localparam int ST_LINE = 0;
  localparam int ST_CTRL = 1;
  localparam int ST_DATA = 2;
  localparam int ST_GPIO = 6;
  localparam int GLB_LINE = 0;
  localparam int GLB_GPIO = 6;
  localparam int EP_CTRL = 0;
  localparam int EP_DATA = 1;
  localparam int CTL_KBD_SEL = 0;
  localparam logic [7:0] ST_MASK = 8'h47;

  // Timing: the line condition must last this long before it counts.
  localparam int CLK_PERIOD_NS = 10;
  localparam int DETECT_TIME_US = 256;
  localparam int DETECT_CYCLES =
    (DETECT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Line detector states, Gray coded along idle, count, long.
  typedef enum logic [1:0] {
    DET_IDLE = 2'b00,
    DET_COUNT = 2'b01,
    DET_LONG = 2'b11
  } det_state_e;

  // Classic Wishbone request from the bus master.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic sel;
    logic [7:0] adr;
    logic [7:0] dat;
  } wb_req_s;

  // Events and levels from the USB serial engine, same clock.
  typedef struct packed {
    logic d_out_valid;
    logic d_out_crc_bad;
    logic d_ack_out_mode;
    logic d_nak_stall;
    logic d_in_acked;
    logic c_setup_mode;
    logic c_status_zlp;
    logic c_out_valid;
    logic c_out_invalid;
    logic c_ack_out_mode;
    logic c_nak_stall;
  } sie_event_s;

endpackage

//--- core/usb_irq_sources.sv
/*
 * Interrupt sources of a low-speed USB peripheral controller: line detector for
 * bus reset or keyboard-line activity, control and data endpoint events, and
 * per-pin GPIO edge interrupts, with sticky status, clear and enable registers.
 * Assumes a classic Wishbone master on clk_i, USB, keyboard and GPIO pins that
 * are asynchronous, and serial engine events that are synchronous to clk_i.
 */
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps

module usb_irq_sources #(
  parameter int DETECT_CYCLES = usb_irq_pkg::DETECT_CYCLES,
  parameter int CNT_W = 16,
  parameter int PA_W = 8,
  parameter int PB_W = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire usb_irq_pkg::wb_req_s wb_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic usb_dp_i,
  input wire logic usb_dm_i,
  input wire logic keyboard_data_line_i,
  input wire logic [PA_W-1:0] port_a_i,
  input wire logic [PB_W-1:0] port_b_i,
  input wire usb_irq_pkg::sie_event_s sie_i,
  output logic usb_addr_clear_o,
  output logic [7:0] pending_o,
  output logic irq_o
);

  localparam int PIN_W = PA_W + PB_W + 3;
  localparam int GP_W = PA_W + PB_W;

  // Bus side registers.
  logic ack_reg;
  logic [7:0] dat_reg;
  logic [PA_W-1:0] pa_en_reg;
  logic [PB_W-1:0] pb_en_reg;
  logic [PA_W-1:0] pa_pol_reg;
  logic [PB_W-1:0] pb_pol_reg;
  logic [7:0] glb_en_reg;
  logic [1:0] ep_en_reg;
  logic kbd_sel_reg;
  logic [7:0] status_reg;
  logic [7:0] status_next;

  // Pin synchronisers and detector state.
  logic [PIN_W-1:0] sync1_reg;
  logic [PIN_W-1:0] sync2_reg;
  usb_irq_pkg::det_state_e state_reg;
  usb_irq_pkg::det_state_e state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic addr_clr_reg;

  // GPIO edge state.
  logic [GP_W-1:0] prev_act_reg;
  logic [GP_W-1:0] lock_reg;
  logic [GP_W-1:0] lock_next;

  // Bus decode. Answers come one cycle after the request is seen.
  wire bus_req = wb_i.cyc & wb_i.stb & ~ack_reg;
  wire bus_wr = bus_req & wb_i.we & wb_i.sel;
  wire bus_rd = bus_req & ~wb_i.we;
  wire hit_pa_en = wb_i.adr == usb_irq_pkg::ADR_PA_EN;
  wire hit_pb_en = wb_i.adr == usb_irq_pkg::ADR_PB_EN;
  wire hit_pa_pol = wb_i.adr == usb_irq_pkg::ADR_PA_POL;
  wire hit_pb_pol = wb_i.adr == usb_irq_pkg::ADR_PB_POL;
  wire hit_ctl = wb_i.adr == usb_irq_pkg::ADR_USB_CTL;
  wire hit_glb = wb_i.adr == usb_irq_pkg::ADR_GLB_EN;
  wire hit_ep = wb_i.adr == usb_irq_pkg::ADR_EP_EN;
  wire hit_status = wb_i.adr == usb_irq_pkg::ADR_STATUS;
  wire hit_clear = wb_i.adr == usb_irq_pkg::ADR_CLEAR;

  // Read selection. Write-only and unmapped addresses read as zero.
  wire [7:0] rd_ctl = {7'h00, kbd_sel_reg};
  wire [7:0] rd_ep = {6'h00, ep_en_reg};
  wire [7:0] rd_mux = hit_glb ? glb_en_reg :
                      hit_ep ? rd_ep :
                      hit_ctl ? rd_ctl :
                      hit_status ? status_reg : 8'h00;

  // Register writes; the port enables and polarity are not readable.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_en_reg <= '0;
      pb_en_reg <= '0;
      pa_pol_reg <= '0;
      pb_pol_reg <= '0;
      glb_en_reg <= usb_irq_pkg::RST_BYTE;
      ep_en_reg <= usb_irq_pkg::RST_EP;
      kbd_sel_reg <= usb_irq_pkg::RST_SEL;
    end else if (bus_wr) begin
      if (hit_pa_en) begin
        pa_en_reg <= wb_i.dat[PA_W-1:0];
      end
      if (hit_pb_en) begin
        pb_en_reg <= wb_i.dat[PB_W-1:0];
      end
      if (hit_pa_pol) begin
        pa_pol_reg <= wb_i.dat[PA_W-1:0];
      end
      if (hit_pb_pol) begin
        pb_pol_reg <= wb_i.dat[PB_W-1:0];
      end
      if (hit_glb) begin
        glb_en_reg <= wb_i.dat;
      end
      if (hit_ep) begin
        ep_en_reg <= wb_i.dat[1:0];
      end
      if (hit_ctl) begin
        kbd_sel_reg <= wb_i.dat[usb_irq_pkg::CTL_KBD_SEL];
      end
    end
  end

  // Bus answer: ack for one cycle, read data registered with it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 8'h00;
    end else begin
      ack_reg <= bus_req;
      dat_reg <= bus_rd ? rd_mux : 8'h00;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // Two-stage synchronisers; nothing but the second stage reads the first.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= {keyboard_data_line_i, usb_dm_i, usb_dp_i, port_b_i, port_a_i};
      sync2_reg <= sync1_reg;
    end
  end

  wire [GP_W-1:0] gp_pin = sync2_reg[GP_W-1:0];
  wire dp_s = sync2_reg[GP_W];
  wire dm_s = sync2_reg[GP_W+1];
  wire kbd_s = sync2_reg[GP_W+2];

  // The selected line condition feeds one shared duration counter.
  wire se0 = ~dp_s & ~dm_s;
  wire line_cond = kbd_sel_reg ? ~kbd_s : se0;
  wire cnt_last = cnt_reg == CNT_W'(DETECT_CYCLES - 1);
  wire det_count = state_reg == usb_irq_pkg::DET_COUNT;
  wire det_long = state_reg == usb_irq_pkg::DET_LONG;

  // Keyboard mode fires when the low becomes long; bus reset fires when it ends.
  wire kbd_event = kbd_sel_reg & det_count & line_cond & cnt_last;
  wire se0_event = ~kbd_sel_reg & det_long & ~line_cond;
  wire line_event = kbd_event | se0_event;

  // Detector next state. A glitch in the condition restarts the count.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      usb_irq_pkg::DET_IDLE: begin
        cnt_next = '0;
        if (line_cond) begin
          state_next = usb_irq_pkg::DET_COUNT;
        end
      end
      usb_irq_pkg::DET_COUNT: begin
        if (!line_cond) begin
          state_next = usb_irq_pkg::DET_IDLE;
        end else if (cnt_last) begin
          state_next = usb_irq_pkg::DET_LONG;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      usb_irq_pkg::DET_LONG: begin
        if (!line_cond) begin
          state_next = usb_irq_pkg::DET_IDLE;
        end
      end
      default: begin
        state_next = usb_irq_pkg::DET_IDLE;
        cnt_next = '0;
      end
    endcase
  end

  // The address clear follows the long state so it covers the whole event.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= usb_irq_pkg::DET_IDLE;
      cnt_reg <= '0;
      addr_clr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      addr_clr_reg <= state_next == usb_irq_pkg::DET_LONG;
    end
  end

  assign usb_addr_clear_o = addr_clr_reg;

  // GPIO: active level per pin from polarity, edge into active level.
  wire [GP_W-1:0] gp_pol = {pb_pol_reg, pa_pol_reg};
  wire [GP_W-1:0] gp_en = {pb_en_reg, pa_en_reg};
  wire [GP_W-1:0] gp_act = ~(gp_pin ^ gp_pol);
  wire [GP_W-1:0] gp_edge = gp_act & ~prev_act_reg & gp_en;
  wire lock_held = |(lock_reg & gp_act & gp_en);
  wire gpio_event = (|gp_edge) & ~lock_held;

  // The lock names the pin that fired; it lapses when that pin is idle or disabled.
  assign lock_next = gpio_event ? gp_edge : (lock_held ? lock_reg : '0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_act_reg <= '1;
      lock_reg <= '0;
    end else begin
      prev_act_reg <= gp_act;
      lock_reg <= lock_next;
    end
  end

  // Endpoint events. In ack-OUT modes bad data still interrupts; firmware checks it.
  wire data_event = sie_i.d_out_valid |
                    (sie_i.d_out_crc_bad & sie_i.d_ack_out_mode) |
                    sie_i.d_nak_stall |
                    sie_i.d_in_acked;
  wire ctrl_event = sie_i.c_setup_mode |
                    sie_i.c_status_zlp |
                    sie_i.c_out_valid |
                    (sie_i.c_out_invalid & sie_i.c_ack_out_mode) |
                    sie_i.c_nak_stall;

  // Sticky status; a set in the clearing cycle wins so no event is lost.
  logic [7:0] set_vec;
  always_comb begin
    set_vec = 8'h00;
    set_vec[usb_irq_pkg::ST_LINE] = line_event;
    set_vec[usb_irq_pkg::ST_CTRL] = ctrl_event;
    set_vec[usb_irq_pkg::ST_DATA] = data_event;
    set_vec[usb_irq_pkg::ST_GPIO] = gpio_event;
  end

  wire [7:0] clr_vec = (bus_wr & hit_clear) ? wb_i.dat : 8'h00;
  assign status_next = ((status_reg & ~clr_vec) | set_vec) & usb_irq_pkg::ST_MASK;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= usb_irq_pkg::RST_BYTE;
    end else begin
      status_reg <= status_next;
    end
  end

  // Enables in status layout; the timer and wake-up enables gate nothing here.
  logic [7:0] en_vec;
  always_comb begin
    en_vec = 8'h00;
    en_vec[usb_irq_pkg::ST_LINE] = glb_en_reg[usb_irq_pkg::GLB_LINE];
    en_vec[usb_irq_pkg::ST_CTRL] = ep_en_reg[usb_irq_pkg::EP_CTRL];
    en_vec[usb_irq_pkg::ST_DATA] = ep_en_reg[usb_irq_pkg::EP_DATA];
    en_vec[usb_irq_pkg::ST_GPIO] = glb_en_reg[usb_irq_pkg::GLB_GPIO];
  end

  // Pending sources go to the vector logic; the line is high while any is enabled.
  assign pending_o = status_reg & en_vec;
  assign irq_o = |(status_reg & en_vec);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_line_select: assert property (
    line_event |-> (kbd_sel_reg ? !kbd_s : $past(se0)))
    else $error("line event not from the selected condition");

  // Only keyboard mode records the event at the full count; bus reset waits for the end.
  chk_detect_time: assert property (
    det_count && line_cond && cnt_last |=>
      det_long && (status_reg[usb_irq_pkg::ST_LINE] || !$past(kbd_sel_reg)))
    else $error("long condition not taken at the full count");

  chk_reset_end: assert property (
    !kbd_sel_reg && det_long && se0 ##1 !se0 && !kbd_sel_reg |->
      se0_event ##1 status_reg[usb_irq_pkg::ST_LINE])
    else $error("bus reset end did not raise the line event");

  chk_reset_wait: assert property (
    !kbd_sel_reg && se0 |=> !$rose(status_reg[usb_irq_pkg::ST_LINE]))
    else $error("bus reset raised the line event before it ended");

  chk_kbd_early: assert property (
    kbd_sel_reg && det_long |-> !se0_event && $past(det_count || det_long))
    else $error("keyboard mode long state reached wrongly");

  chk_addr_clear: assert property (
    det_long |-> usb_addr_clear_o)
    else $error("device address not cleared during the event");

  chk_ep_reset: assert property (
    $fell(rst_i) |-> ep_en_reg == 2'h0 && glb_en_reg == 8'h00)
    else $error("enable registers not zero after reset");

  chk_data_out: assert property (
    sie_i.d_out_crc_bad && sie_i.d_ack_out_mode |=> status_reg[usb_irq_pkg::ST_DATA])
    else $error("ack-OUT bad packet did not raise data interrupt");

  // Each endpoint condition but the two valid-OUT ones is watched on its own so a lone pulse is checked.
  chk_nak_stall: assert property (
    sie_i.c_nak_stall |=> status_reg[usb_irq_pkg::ST_CTRL])
    else $error("NAK or STALL did not raise the control endpoint interrupt");

  chk_data_nak: assert property (
    sie_i.d_nak_stall |=> status_reg[usb_irq_pkg::ST_DATA])
    else $error("NAK or STALL did not raise the data endpoint interrupt");

  chk_in_acked: assert property (
    sie_i.d_in_acked |=> status_reg[usb_irq_pkg::ST_DATA])
    else $error("host ACK after IN did not raise the data endpoint interrupt");

  chk_setup_mode: assert property (
    sie_i.c_setup_mode |=> status_reg[usb_irq_pkg::ST_CTRL])
    else $error("SETUP-accepting mode did not raise the control interrupt");

  chk_status_zlp: assert property (
    sie_i.c_status_zlp |=> status_reg[usb_irq_pkg::ST_CTRL])
    else $error("status stage zero-length packet did not raise the control interrupt");

  chk_ctrl_out: assert property (
    sie_i.c_out_invalid && sie_i.c_ack_out_mode |=> status_reg[usb_irq_pkg::ST_CTRL])
    else $error("ack-OUT control data did not raise the control interrupt");

  chk_wo_read: assert property (
    bus_rd && (hit_pa_en || hit_pb_pol) |=> wb_ack_o && wb_dat_o == 8'h00)
    else $error("write-only register did not read as zero");

  chk_gpio_block: assert property (
    lock_held |-> !gpio_event ##1 (lock_reg == $past(lock_reg) || !(|lock_reg)))
    else $error("GPIO event passed while another pin held the lock");

  chk_gpio_quiet: assert property (
    lock_held |=> !$rose(status_reg[usb_irq_pkg::ST_GPIO]))
    else $error("GPIO status rose while a pin held the lock");

  chk_irq_level: assert property (
    $rose(|(status_reg & en_vec)) |-> irq_o && $past(!irq_o))
    else $error("interrupt line did not follow pending sources");

  cov_bus_reset: cover property (!kbd_sel_reg && det_long ##1 se0_event);
  cov_kbd_event: cover property (kbd_event ##1 usb_addr_clear_o);
  cov_gpio_block: cover property (gpio_event ##1 lock_held && (|gp_edge));
  cov_set_clear: cover property (bus_wr && hit_clear && (|set_vec));

endmodule

//--- bench/cpu_irq_model.sv
/*
 * Model of the CPU core's interrupt acknowledge and vector logic.
 * Assumes the level interrupt and the pending byte of the source block on one clock.
 */
`timescale 1ns/1ps

module cpu_irq_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic irq_i,
  input wire logic [7:0] pending_i,
  output logic [3:0] vector_o
);
  logic [3:0] pick;

  // Fixed priority: the line source wins, GPIO comes last; zero means no request.
  assign pick = pending_i[0] ? 4'h1 : pending_i[1] ? 4'h4 :
                pending_i[2] ? 4'h5 : pending_i[6] ? 4'ha : 4'h0;

  // The vector is latched a cycle late, as an acknowledge stage would see it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vector_o <= 4'h0;
    end else begin
      vector_o <= irq_i ? pick : 4'h0;
    end
  end
endmodule

//--- bench/usb_irq_sources_test.sv
/*
 * Self-checking bench for the USB, keyboard-line and GPIO interrupt sources.
 * Assumes the classic Wishbone timing of the block and a shortened detect count.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module usb_irq_sources_test;
  localparam int DET = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  usb_irq_pkg::wb_req_s wb = '0;
  usb_irq_pkg::sie_event_s usb_serial_engine = '0;
  logic dp = 1'b1;
  logic dm = 1'b0;
  logic kbd = 1'b1;
  logic [7:0] pa = 8'hff;
  logic [1:0] pb = 2'h3;
  logic [7:0] rdat, pend, q;
  logic ack, irq, aclr;
  logic [3:0] vec;
  int bad_count = 0;
  int n_checks = 0;
  logic [7:0] adrs [10] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h10};
  logic [10:0] evs [9] = '{11'h400, 11'h300, 11'h080, 11'h040, 11'h020, 11'h010, 11'h008,
                           11'h006, 11'h001};

  always #5 clk_i = ~clk_i;

  usb_irq_sources #(.DETECT_CYCLES(DET)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .usb_dp_i(dp), .usb_dm_i(dm),
    .keyboard_data_line_i(kbd), .port_a_i(pa), .port_b_i(pb), .sie_i(usb_serial_engine),
    .usb_addr_clear_o(aclr), .pending_o(pend), .irq_o(irq));

  cpu_irq_model cpu (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq), .pending_i(pend),
    .vector_o(vec));

  // Prints the verdict and stops; also the landing place of every timeout.
  task automatic complete_run;
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One classic cycle; the request holds until ack is seen, then idles a cycle.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    wb <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 1'b1, adr: a, dat: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      bad_count++;
      complete_run();
    end
    q = rdat;
    wb <= '0;
    @(posedge clk_i);
  endtask

  function automatic logic probe(input int k);
    return (k < 8) ? pend[k] : aclr;
  endfunction

  // Waits for a pending bit, or the address clear when k is 8, to reach a level.
  task automatic wait_lvl(input int k, input logic lvl, input int lim);
    int n;
    n = 0;
    while (probe(k) !== lvl && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("wait level", lvl, probe(k))
    if (probe(k) !== lvl) complete_run();
  endtask

  initial begin
    tick(8);
    rst_i <= 1'b0;
    tick(1);
    // Every register and one unmapped place read zero after reset.
    foreach (adrs[i]) begin
      xfer(adrs[i], 1'b0, 8'h00);
      `CHK("reset value", 8'h00, q)
    end
    foreach (adrs[i]) begin
      if (i < 4 || i == 9) begin
        xfer(adrs[i], 1'b1, 8'hff);
        xfer(adrs[i], 1'b0, 8'h00);
        `CHK("write-only reads zero", 8'h00, q)
        xfer(adrs[i], 1'b1, 8'h00);
      end
    end
    xfer(8'h20, 1'b1, 8'hff);
    xfer(8'h20, 1'b0, 8'h00);
    `CHK("global enable", 8'hff, q)
    xfer(8'h21, 1'b1, 8'hfc);
    xfer(8'h21, 1'b0, 8'h00);
    `CHK("endpoint enable reserved", 8'h00, q)
    // A masked endpoint event is recorded but raises no interrupt.
    usb_serial_engine <= usb_irq_pkg::sie_event_s'(evs[0]);
    tick(1);
    usb_serial_engine <= '0;
    tick(2);
    `CHK("masked irq", 1'b0, irq)
    xfer(8'h21, 1'b1, 8'h03);
    xfer(8'h21, 1'b0, 8'h00);
    `CHK("endpoint enable", 8'h03, q)
    tick(1);
    `CHK("enabled irq", 1'b1, irq)
    xfer(8'h23, 1'b1, 8'h07);
    // Each endpoint condition sets its endpoint's status bit and vector.
    foreach (evs[i]) begin
      usb_serial_engine <= usb_irq_pkg::sie_event_s'(evs[i]);
      tick(1);
      usb_serial_engine <= '0;
      tick(1);
      xfer(8'h22, 1'b0, 8'h00);
      `CHK("endpoint status", (i < 4) ? 8'h04 : 8'h02, q)
      `CHK("endpoint vector", (i < 4) ? 4'h5 : 4'h4, vec)
      xfer(8'h23, 1'b1, 8'h07);
      tick(1);
      `CHK("irq after clear", 1'b0, irq)
    end
    // Keyboard-line mode: the long low raises the line source and clears the address.
    xfer(8'h1f, 1'b1, 8'h01);
    kbd <= 1'b0;
    tick(DET / 2 - 1);
    `CHK("line not early", 1'b0, pend[0])
    wait_lvl(0, 1'b1, 2 * DET);
    `CHK("address clear", 1'b1, aclr)
    tick(1);
    `CHK("line vector", 4'h1, vec)
    kbd <= 1'b1;
    wait_lvl(8, 1'b0, DET / 2);
    xfer(8'h23, 1'b1, 8'h01);
    // Bus-reset mode ignores the keyboard line and drops a short single-ended zero.
    xfer(8'h1f, 1'b1, 8'h00);
    kbd <= 1'b0;
    dp <= 1'b0;
    tick(5);
    dp <= 1'b1;
    tick(2 * DET);
    kbd <= 1'b1;
    `CHK("short reset dropped", 1'b0, pend[0])
    dp <= 1'b0;
    wait_lvl(8, 1'b1, 2 * DET);
    tick(4);
    `CHK("reset waits for end", 1'b0, pend[0])
    dp <= 1'b1;
    wait_lvl(0, 1'b1, DET / 2);
    `CHK("address clear ends", 1'b0, aclr)
    xfer(8'h23, 1'b1, 8'h01);
    // GPIO falling edge fires; a second pin is locked out while the first stays low.
    xfer(8'h04, 1'b1, 8'h03);
    pa <= 8'hfe;
    wait_lvl(6, 1'b1, 10);
    tick(1);
    `CHK("gpio vector", 4'ha, vec)
    xfer(8'h23, 1'b1, 8'h40);
    pa <= 8'hfc;
    tick(8);
    `CHK("gpio lock", 1'b0, pend[6])
    pa <= 8'hff;
    tick(8);
    `CHK("rising ignored", 1'b0, pend[6])
    xfer(8'h04, 1'b1, 8'h00);
    // Port B rising polarity on its lowest pin.
    xfer(8'h07, 1'b1, 8'h01);
    xfer(8'h05, 1'b1, 8'h01);
    pb <= 2'h2;
    tick(8);
    `CHK("falling ignored", 1'b0, pend[6])
    pb <= 2'h3;
    wait_lvl(6, 1'b1, 10);
    xfer(8'h23, 1'b1, 8'h40);
    xfer(8'h22, 1'b0, 8'h00);
    `CHK("status cleared", 8'h00, q)
    // A reset in mid-run must drop the enables written above.
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(1);
    `CHK("irq after reset", 1'b0, irq)
    xfer(8'h20, 1'b0, 8'h00);
    `CHK("global enable reset", 8'h00, q)
    xfer(8'h21, 1'b0, 8'h00);
    `CHK("endpoint enable reset", 8'h00, q)
    complete_run();
  end
endmodule
